// ==== rtl/core_pkg.sv ====
package core_pkg;
   localparam int STACK_DEPTH = 8;
   localparam int PC_WIDTH = 13;
   localparam int DATA_WIDTH = 8;

   // Data memory map
   localparam logic [7:0] ADDR_IND_A = 8'h00;
   localparam logic [7:0] ADDR_PTR_A = 8'h01;
   localparam logic [7:0] ADDR_IND_B = 8'h02;
   localparam logic [7:0] ADDR_PTR_B = 8'h03;
   localparam logic [7:0] ADDR_ACC = 8'h05;
   localparam logic [7:0] ADDR_FLAGS = 8'h0A;
   localparam logic [7:0] ADDR_IRQ = 8'h0B;
   localparam logic [7:0] ADDR_GP_LO = 8'h30;
   localparam logic [7:0] ADDR_GP_HI = 8'hFF;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Flags register fields
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_SWRAP = 3;
   localparam int FLAG_HALTED = 4;
   localparam int FLAG_WDEXP = 5;

   // Interrupt control fields
   localparam int IRQ_GLOBAL = 0;
   localparam int IRQ_T0_EN = 2;
   localparam int IRQ_T1_EN = 3;
   localparam int IRQ_T0_PEND = 5;
   localparam int IRQ_T1_PEND = 6;
   localparam logic [7:0] IRQ_RW_MASK = 8'h6D;

   // Reset values
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   // Interrupt vectors
   localparam logic [PC_WIDTH-1:0] VEC_TIMER0 = 13'h0008;
   localparam logic [PC_WIDTH-1:0] VEC_TIMER1 = 13'h000C;

   typedef enum logic [4:0] {
      OP_ADD = 5'h00, OP_ADC = 5'h01, OP_SUB = 5'h02, OP_SBC = 5'h03,
      OP_DAA = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
      OP_CPL = 5'h08, OP_RL = 5'h09, OP_RR = 5'h0A, OP_RLC = 5'h0B,
      OP_RRC = 5'h0C, OP_INC = 5'h0D, OP_DEC = 5'h0E, OP_MOVA = 5'h0F,
      OP_MOVM = 5'h10, OP_SZ = 5'h11, OP_SNZ = 5'h12
   } alu_op_t;

   typedef struct packed {
      alu_op_t op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic use_imm;
      logic to_mem;
   } exec_req_t;

   typedef struct packed {
      logic ack;
      logic [PC_WIDTH-1:0] vector;
   } irq_take_t;
endpackage

// ==== rtl/mcu_stack_status_interrupt_core.sv ====
// Operation
// - Eight-level hidden return stack, program counter only
// - Calls and acks push; returns pop
// - Reset points stack index at top
// - Full stack records request, delays acknowledge
// - Call on full stack drops oldest
// - 256 bytes; unused low space reads zero
// - Locations 00H/02H access through pointers
// - Self-indirect access reads zero, writes nothing
// - Accumulator at 05H, handles immediate data
// - Full 8-bit ALU operation set
// - Bit 0 carry, no-borrow, rotate carry
// - Bit 1 low-nibble carry or no-borrow
// - Bit 2 set on zero result
// - Bit 3 carry-in differs carry-out of msb
// - Halt and watchdog flag set/clear sources
// - Software cannot write bits 4-5; 6-7 zero
// - Status never saved on call or entry
// - Timer 0 pending, vector 08H, clears global
// - Timer 1 likewise, bits 3/6, vector 0CH
// - Inside handler requests only pend
// - Interrupt return sets global enable; plain not
// - Service on phase pulse edge; timer 0 first
// - Pending flags hold until serviced or cleared
// - Bit 0 global, bit 2 timer 0 enable
`timescale 1ns/1ps
`default_nettype none
module mcu_stack_status_interrupt_core
   import core_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic call_op,
   input wire logic plain_back_op,
   input wire logic irq_back_op,
   input wire logic [PC_WIDTH-1:0] instr_pointer,
   input wire logic exec_valid,
   input wire exec_req_t exec_req,
   input wire logic halt_op,
   input wire logic watchdog_kick_op,
   input wire logic watchdog_timeout,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic phase_two_pulse,
   output logic [PC_WIDTH-1:0] return_pc,
   output logic return_valid,
   output irq_take_t irq_take,
   output logic skip_next,
   output logic [7:0] acc_out,
   output logic [7:0] flags_out,
   output logic [7:0] irq_ctrl_out,
   output logic stack_full
);
   localparam int IDXW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << IDXW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two of at least 2");
   end

   logic [PC_WIDTH-1:0] stack_mem [DEPTH];
   logic [IDXW-1:0] return_depth_index;
   logic [IDXW:0] fill_count;
   logic [7:0] ram [ADDR_GP_LO:ADDR_GP_HI];
   logic [7:0] ptr_reg_a;
   logic [7:0] ptr_reg_b;
   logic [7:0] acc_reg;
   logic arith_wrap_out_flag;
   logic half_nibble_flag;
   logic null_result_flag;
   logic signed_wrap_flag;
   logic halted_flag;
   logic watchdog_expired_flag;
   logic global_irq_allow;
   logic timer0_irq_allow;
   logic timer1_irq_allow;
   logic timer0_irq_pending;
   logic timer1_irq_pending;
   logic phase_prev_reg;
   logic [7:0] flags_view;
   logic [7:0] irq_view;

   assign flags_view = {2'b00, watchdog_expired_flag, halted_flag, signed_wrap_flag,
                        null_result_flag, half_nibble_flag, arith_wrap_out_flag};
   assign irq_view = {1'b0, timer1_irq_pending, timer0_irq_pending, 1'b0,
                      timer1_irq_allow, timer0_irq_allow, 1'b0, global_irq_allow};
   assign stack_full = (fill_count == (IDXW + 1)'(DEPTH));
   assign acc_out = acc_reg;
   assign flags_out = flags_view;
   assign irq_ctrl_out = irq_view;

   // Interrupt arbitration on the rising edge of the phase pulse
   logic phase_edge;
   logic t0_ready;
   logic t1_ready;
   logic irq_fire;
   logic [PC_WIDTH-1:0] irq_vec;
   assign phase_edge = phase_two_pulse && !phase_prev_reg;
   assign t0_ready = timer0_irq_pending && timer0_irq_allow;
   assign t1_ready = timer1_irq_pending && timer1_irq_allow;
   // Withheld while stack is full or another stack operation is in flight
   assign irq_fire = phase_edge && global_irq_allow && (t0_ready || t1_ready)
                     && !stack_full && !call_op && !plain_back_op && !irq_back_op;
   assign irq_vec = t0_ready ? VEC_TIMER0 : VEC_TIMER1;

   logic do_push;
   logic do_pop;
   assign do_push = call_op || irq_fire;
   assign do_pop = (plain_back_op || irq_back_op) && !call_op;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_prev_reg <= 1'b0;
      end else begin
         phase_prev_reg <= phase_two_pulse;
      end
   end

   // Return stack: circular, so a push on a full stack overwrites the oldest
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         stack_mem[return_depth_index] <= instr_pointer;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         return_depth_index <= '0;
         fill_count <= '0;
      end else if (do_push) begin
         return_depth_index <= return_depth_index + 1'b1;
         if (!stack_full) begin
            fill_count <= fill_count + 1'b1;
         end
      end else if (do_pop && fill_count != '0) begin
         return_depth_index <= return_depth_index - 1'b1;
         fill_count <= fill_count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         return_pc <= '0;
         return_valid <= 1'b0;
      end else begin
         return_valid <= do_pop;
         if (do_pop) begin
            return_pc <= stack_mem[return_depth_index - 1'b1];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_take <= '0;
      end else begin
         irq_take.ack <= irq_fire;
         if (irq_fire) begin
            irq_take.vector <= irq_vec;
         end
      end
   end

   // Data memory read, resolving pointers
   function automatic logic [7:0] read_loc(input logic [7:0] a);
      logic [7:0] v;
      v = READ_ZERO;
      case (a)
         ADDR_PTR_A: v = ptr_reg_a;
         ADDR_PTR_B: v = ptr_reg_b;
         ADDR_ACC: v = acc_reg;
         ADDR_FLAGS: v = flags_view;
         ADDR_IRQ: v = irq_view;
         default: begin
            if (a >= ADDR_GP_LO) begin
               v = ram[a];
            end
         end
      endcase
      return v;
   endfunction

   logic [7:0] eff_addr;
   logic [7:0] operand;
   assign eff_addr = (exec_req.addr == ADDR_IND_A) ? ptr_reg_a :
                     (exec_req.addr == ADDR_IND_B) ? ptr_reg_b : exec_req.addr;
   // A pointer aiming at an indirect location falls to the zero default
   assign operand = exec_req.use_imm ? exec_req.imm : read_loc(eff_addr);

   // ALU
   logic [7:0] alu_y;
   logic [7:0] result;
   logic cin;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] bit7_sum;
   logic arith;
   logic set_carry;
   logic set_zero;
   logic new_carry;
   logic [8:0] daa_val;
   logic writes_result;
   logic skip_now;

   always_comb begin
      alu_y = operand;
      cin = 1'b0;
      case (exec_req.op)
         OP_ADC: cin = arith_wrap_out_flag;
         OP_SUB: begin
            alu_y = ~operand;
            cin = 1'b1;
         end
         OP_SBC: begin
            alu_y = ~operand;
            cin = arith_wrap_out_flag;
         end
         default: cin = 1'b0;
      endcase
   end

   assign sum = {1'b0, acc_reg} + {1'b0, alu_y} + {8'h00, cin};
   assign low_sum = {1'b0, acc_reg[3:0]} + {1'b0, alu_y[3:0]} + {4'h0, cin};
   assign bit7_sum = {1'b0, acc_reg[6:0]} + {1'b0, alu_y[6:0]} + {7'h00, cin};

   always_comb begin
      daa_val = {1'b0, operand};
      if (operand[3:0] > 4'h9 || half_nibble_flag) begin
         daa_val = daa_val + 9'h006;
      end
      if (daa_val[7:4] > 4'h9 || arith_wrap_out_flag || daa_val[8]) begin
         daa_val = daa_val + 9'h060;
      end
   end

   always_comb begin
      result = operand;
      arith = 1'b0;
      set_carry = 1'b0;
      set_zero = 1'b0;
      new_carry = arith_wrap_out_flag;
      writes_result = 1'b1;
      skip_now = 1'b0;
      case (exec_req.op)
         OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
            result = sum[7:0];
            arith = 1'b1;
            set_carry = 1'b1;
            set_zero = 1'b1;
            new_carry = sum[8];
         end
         OP_DAA: begin
            result = daa_val[7:0];
            set_carry = 1'b1;
            new_carry = daa_val[8] || arith_wrap_out_flag;
         end
         OP_AND: begin
            result = acc_reg & operand;
            set_zero = 1'b1;
         end
         OP_OR: begin
            result = acc_reg | operand;
            set_zero = 1'b1;
         end
         OP_XOR: begin
            result = acc_reg ^ operand;
            set_zero = 1'b1;
         end
         OP_CPL: begin
            result = ~operand;
            set_zero = 1'b1;
         end
         OP_RL: result = {operand[6:0], operand[7]};
         OP_RR: result = {operand[0], operand[7:1]};
         OP_RLC: begin
            result = {operand[6:0], arith_wrap_out_flag};
            set_carry = 1'b1;
            new_carry = operand[7];
         end
         OP_RRC: begin
            result = {arith_wrap_out_flag, operand[7:1]};
            set_carry = 1'b1;
            new_carry = operand[0];
         end
         OP_INC: begin
            result = operand + 8'h01;
            set_zero = 1'b1;
         end
         OP_DEC: begin
            result = operand - 8'h01;
            set_zero = 1'b1;
         end
         OP_MOVA: result = operand;
         OP_MOVM: result = acc_reg;
         OP_SZ: begin
            writes_result = 1'b0;
            skip_now = (operand == 8'h00);
         end
         OP_SNZ: begin
            writes_result = 1'b0;
            skip_now = (operand != 8'h00);
         end
         default: writes_result = 1'b0;
      endcase
   end

   logic mem_wr;
   logic acc_wr;
   assign mem_wr = exec_valid && writes_result && exec_req.to_mem && !exec_req.use_imm;
   assign acc_wr = exec_valid && writes_result && !(exec_req.to_mem && !exec_req.use_imm);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         skip_next <= 1'b0;
      end else begin
         skip_next <= exec_valid && skip_now;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (mem_wr && eff_addr >= ADDR_GP_LO) begin
         ram[eff_addr] <= result;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_reg_a <= PTR_RESET;
         ptr_reg_b <= PTR_RESET;
      end else if (mem_wr) begin
         if (eff_addr == ADDR_PTR_A) begin
            ptr_reg_a <= result;
         end
         if (eff_addr == ADDR_PTR_B) begin
            ptr_reg_b <= result;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_reg <= ACC_RESET;
      end else if (acc_wr || (mem_wr && eff_addr == ADDR_ACC)) begin
         acc_reg <= result;
      end
   end

   // Arithmetic flags; the ALU update wins over a store to the flags register
   logic flags_store;
   assign flags_store = mem_wr && eff_addr == ADDR_FLAGS;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         {signed_wrap_flag, null_result_flag, half_nibble_flag, arith_wrap_out_flag} <= FLAGS_RESET;
      end else if (exec_valid) begin
         if (flags_store) begin
            arith_wrap_out_flag <= result[FLAG_CARRY];
            half_nibble_flag <= result[FLAG_HALF];
            null_result_flag <= result[FLAG_ZERO];
            signed_wrap_flag <= result[FLAG_SWRAP];
         end
         if (set_carry) begin
            arith_wrap_out_flag <= new_carry;
         end
         if (arith) begin
            half_nibble_flag <= low_sum[4];
            signed_wrap_flag <= bit7_sum[7] ^ sum[8];
         end
         if (set_zero) begin
            null_result_flag <= (result == 8'h00);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         halted_flag <= 1'b0;
         watchdog_expired_flag <= 1'b0;
      end else begin
         if (halt_op) begin
            halted_flag <= 1'b1;
         end else if (watchdog_kick_op) begin
            halted_flag <= 1'b0;
         end
         if (watchdog_timeout) begin
            watchdog_expired_flag <= 1'b1;
         end else if (halt_op || watchdog_kick_op) begin
            watchdog_expired_flag <= 1'b0;
         end
      end
   end

   // Interrupt control register
   logic irq_store;
   assign irq_store = mem_wr && eff_addr == ADDR_IRQ;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         {timer1_irq_allow, timer0_irq_allow} <= 2'b00;
      end else if (irq_store) begin
         timer0_irq_allow <= result[IRQ_T0_EN];
         timer1_irq_allow <= result[IRQ_T1_EN];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         global_irq_allow <= IRQ_RESET[IRQ_GLOBAL];
      end else if (irq_fire) begin
         global_irq_allow <= 1'b0;
      end else if (irq_back_op) begin
         global_irq_allow <= 1'b1;
      end else if (irq_store) begin
         global_irq_allow <= result[IRQ_GLOBAL];
      end
   end

   // Overflow sets win over both acknowledge and software clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_irq_pending <= IRQ_RESET[IRQ_T0_PEND];
         timer1_irq_pending <= IRQ_RESET[IRQ_T1_PEND];
      end else begin
         if (timer0_overflow) begin
            timer0_irq_pending <= 1'b1;
         end else if (irq_fire && t0_ready) begin
            timer0_irq_pending <= 1'b0;
         end else if (irq_store) begin
            timer0_irq_pending <= result[IRQ_T0_PEND];
         end
         if (timer1_overflow) begin
            timer1_irq_pending <= 1'b1;
         end else if (irq_fire && !t0_ready) begin
            timer1_irq_pending <= 1'b0;
         end else if (irq_store) begin
            timer1_irq_pending <= result[IRQ_T1_PEND];
         end
      end
   end
endmodule // mcu_stack_status_interrupt_core
`default_nettype wire

// ==== verif/core_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_props
   import core_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic call_op,
   input wire logic plain_back_op,
   input wire logic irq_back_op,
   input wire logic exec_valid,
   input wire logic halt_op,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic phase_two_pulse,
   input wire logic return_valid,
   input wire irq_take_t irq_take,
   input wire logic [7:0] flags_out,
   input wire logic [7:0] irq_ctrl_out,
   input wire logic stack_full
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire logic quiet = !call_op && !plain_back_op && !irq_back_op;
   wire logic t0_due = irq_ctrl_out[IRQ_T0_EN] && irq_ctrl_out[IRQ_T0_PEND];
   wire logic t1_due = irq_ctrl_out[IRQ_T1_EN] && irq_ctrl_out[IRQ_T1_PEND];
   sequence s_rise;
      !phase_two_pulse ##1 phase_two_pulse;
   endsequence
   sequence s_ready;
      irq_ctrl_out[IRQ_GLOBAL] && !stack_full && quiet;
   endsequence
   a_t0_take: assert property (s_rise ##0 (s_ready and t0_due) |=>
      irq_take.ack && irq_take.vector == VEC_TIMER0) else $error("timer 0 not taken");
   a_t1_take: assert property (s_rise ##0 (s_ready and t1_due && !t0_due) |=>
      irq_take.ack && irq_take.vector == VEC_TIMER1) else $error("timer 1 not taken");
   a_ack_cause: assert property (irq_take.ack |-> $past(phase_two_pulse) &&
      !$past(phase_two_pulse, 2) && !$past(stack_full) && !irq_ctrl_out[IRQ_GLOBAL])
      else $error("acknowledge without cause");
   a_full_block: assert property (stack_full && !plain_back_op && !irq_back_op |=>
      !irq_take.ack) else $error("acknowledge on full stack");
   a_pend0_set: assert property (timer0_overflow |=> irq_ctrl_out[IRQ_T0_PEND])
      else $error("timer 0 pending missing");
   a_pend1_set: assert property (timer1_overflow |=> irq_ctrl_out[IRQ_T1_PEND])
      else $error("timer 1 pending missing");
   a_pend_holds: assert property (irq_ctrl_out[IRQ_T1_PEND] && !exec_valid |=>
      irq_ctrl_out[IRQ_T1_PEND] || (irq_take.ack && irq_take.vector == VEC_TIMER1))
      else $error("pending flag lost");
   a_irq_back_op_allow: assert property (irq_back_op && !call_op |=> irq_ctrl_out[IRQ_GLOBAL])
      else $error("global allow not set on return");
   a_pop_answer: assert property ((plain_back_op || irq_back_op) && !call_op |=>
      return_valid) else $error("pop not answered");
   a_halt_mark: assert property (halt_op |=> flags_out[FLAG_HALTED])
      else $error("halted flag not set");
   a_unused_zero: assert property ((irq_ctrl_out & 8'h92) == 8'h00 &&
      flags_out[7:6] == 2'b00) else $error("unused bits not zero");
endmodule // core_props
bind mcu_stack_status_interrupt_core core_props #(.DEPTH(DEPTH)) u_props (
   .sys_clk(sys_clk), .arst_n(arst_n), .call_op(call_op), .plain_back_op(plain_back_op),
   .irq_back_op(irq_back_op), .exec_valid(exec_valid), .halt_op(halt_op),
   .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
   .phase_two_pulse(phase_two_pulse), .return_valid(return_valid), .irq_take(irq_take),
   .flags_out(flags_out), .irq_ctrl_out(irq_ctrl_out), .stack_full(stack_full)
);
`default_nettype wire

// ==== verif/timer_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_partner #(
   parameter int PHASE_HALF = 4
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic fire0,
   input wire logic fire1,
   output logic timer0_overflow,
   output logic timer1_overflow,
   output logic phase_two_pulse
);
   int count;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer0_overflow <= 1'b0;
         timer1_overflow <= 1'b0;
      end else begin
         timer0_overflow <= fire0;
         timer1_overflow <= fire1;
      end
   end
   // Free running service phase
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= 0;
         phase_two_pulse <= 1'b0;
      end else if (count == PHASE_HALF - 1) begin
         count <= 0;
         phase_two_pulse <= !phase_two_pulse;
      end else begin
         count <= count + 1;
      end
   end
endmodule // timer_partner
`default_nettype wire

// ==== verif/mcu_stack_status_interrupt_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcu_stack_status_interrupt_core_bench;
   import core_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [5:0] ctl;
   logic [PC_WIDTH-1:0] instr_pointer, return_pc;
   logic exec_valid, fire0, fire1, t0_ovf, t1_ovf, phase, return_valid, stack_full, skip;
   exec_req_t exec_req;
   irq_take_t irq_take;
   logic [7:0] acc_out, flags_out, irq_ctrl_out, r0, r1;
   logic [31:0] seed;
   logic [PC_WIDTH-1:0] exp_q[$];
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   alu_op_t alu_op[18] = '{OP_ADD, OP_SUB, OP_SUB, OP_SBC, OP_RRC, OP_ADC, OP_DAA, OP_AND,
      OP_OR, OP_XOR, OP_CPL, OP_RLC, OP_RL, OP_RR, OP_INC, OP_DEC, OP_SZ, OP_SNZ};
   logic [7:0] a_in[18] = '{8'h7F, 8'h80, 8'h10, 8'h00, 8'h00, 8'h0F, 8'h00, 8'hF0, 8'h50,
      8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h77, 8'h77};
   logic [7:0] b_in[18] = '{8'h01, 8'h80, 8'h20, 8'h00, 8'h01, 8'h00, 8'h9A, 8'h0F, 8'h0A,
      8'hFF, 8'hFF, 8'h40, 8'h81, 8'h01, 8'h41, 8'h01, 8'h00, 8'h00};
   // Flags bit 7 always reads zero, so its slot carries skip_next
   logic [15:0] want[18] = '{16'h800A, 16'h0007, 16'hF002, 16'hFF00, 16'h0001, 16'h1002,
      16'h0003, 16'h0007, 16'h5A03, 16'hC303, 16'h0007, 16'h8106, 16'h0306, 16'h8006,
      16'h4202, 16'h0006, 16'h7786, 16'h7706};

   always #2.5 sys_clk = ~sys_clk;

   mcu_stack_status_interrupt_core dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .call_op(ctl[5]), .plain_back_op(ctl[4]),
      .irq_back_op(ctl[3]), .instr_pointer(instr_pointer), .exec_valid(exec_valid),
      .exec_req(exec_req), .halt_op(ctl[2]), .watchdog_kick_op(ctl[1]),
      .watchdog_timeout(ctl[0]), .timer0_overflow(t0_ovf), .timer1_overflow(t1_ovf),
      .phase_two_pulse(phase), .return_pc(return_pc), .return_valid(return_valid),
      .irq_take(irq_take), .skip_next(skip), .acc_out(acc_out), .flags_out(flags_out),
      .irq_ctrl_out(irq_ctrl_out), .stack_full(stack_full)
   );
   timer_partner partner (
      .sys_clk(sys_clk), .arst_n(arst_n), .fire0(fire0), .fire1(fire1),
      .timer0_overflow(t0_ovf), .timer1_overflow(t1_ovf), .phase_two_pulse(phase)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic run(input alu_op_t op, input logic [7:0] a, input logic [7:0] d,
                      input logic imm, input logic mem);
      @(posedge sys_clk);
      exec_valid <= 1'b1;
      exec_req <= '{op, a, d, imm, mem};
      @(posedge sys_clk);
      exec_valid <= 1'b0;
      #1;
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      run(OP_MOVA, 8'h00, d, 1'b1, 1'b0);
      run(OP_MOVM, a, 8'h00, 1'b0, 1'b1);
   endtask

   task automatic peek(input logic [7:0] a, input logic [7:0] exp);
      run(OP_MOVA, a, 8'h00, 1'b0, 1'b0);
      check(acc_out, exp);
   endtask

   // Pulse control lines for n back-to-back cycles with a counting return address
   task automatic ops(input logic [5:0] v, input int n, input logic [PC_WIDTH-1:0] ip);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         ctl <= v;
         instr_pointer <= ip + PC_WIDTH'(i);
      end
      @(posedge sys_clk);
      ctl <= 6'h00;
      #1;
   endtask

   task automatic fire(input logic f0, input logic f1);
      @(posedge sys_clk);
      fire0 <= f0;
      fire1 <= f1;
      @(posedge sys_clk);
      fire0 <= 1'b0;
      fire1 <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic wait_q;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      #1;
   endtask

   // Returns and acknowledges are matched to the oldest noted expectation
   always @(negedge sys_clk) begin
      if (return_valid === 1'b1 || irq_take.ack === 1'b1) begin
         if (exp_q.size() == 0) exp_q.push_back(13'h1FFF);
         if (return_valid === 1'b1) check(return_pc, exp_q.pop_front());
         else check(irq_take.vector, exp_q.pop_front());
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      ctl = 6'h00;
      exec_valid = 1'b0;
      exec_req = '0;
      instr_pointer = '0;
      fire0 = 1'b0;
      fire1 = 1'b0;
      seed = 32'h0001_6148;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      check({acc_out, flags_out}, 16'h0000);
      check({irq_ctrl_out, 7'h00, stack_full}, 16'h0000);
      seed = lfsr(seed);
      r0 = seed[7:0];
      seed = lfsr(seed);
      r1 = seed[15:8];
      put(ADDR_GP_LO, r0);
      put(ADDR_GP_HI, r1);
      put(ADDR_PTR_A, ADDR_GP_LO);
      put(ADDR_PTR_B, ADDR_GP_HI);
      peek(ADDR_IND_A, r0);
      peek(ADDR_IND_B, r1);
      put(8'h10, 8'hA5);
      peek(8'h10, READ_ZERO);
      put(ADDR_IND_A, 8'h5A);
      peek(ADDR_GP_LO, 8'h5A);
      put(ADDR_PTR_A, ADDR_IND_B);
      peek(ADDR_IND_A, READ_ZERO);
      run(OP_MOVA, 8'h00, 8'h3C, 1'b1, 1'b0);
      peek(ADDR_ACC, 8'h3C);
      for (int i = 0; i < 18; i++) begin
         run(OP_MOVA, 8'h00, a_in[i], 1'b1, 1'b0);
         run(alu_op[i], 8'h00, b_in[i], 1'b1, 1'b0);
         check({acc_out, skip, flags_out[6:0]}, want[i]);
      end
      ops(6'b000100, 1, '0);
      put(ADDR_FLAGS, 8'hFF);
      check(flags_out, 8'h1F);
      ops(6'b000001, 1, '0);
      check(flags_out, 8'h3F);
      ops(6'b000010, 1, '0);
      check(flags_out, 8'h0F);
      ops(6'b100000, 9, 13'h0100);
      check(stack_full, 1'b1);
      for (int i = 8; i > 0; i--) exp_q.push_back(13'h0100 + PC_WIDTH'(i));
      ops(6'b010000, 8, '0);
      wait_q();
      check(stack_full, 1'b0);
      put(ADDR_IRQ, 8'h0C);
      fire(1'b1, 1'b1);
      check(irq_ctrl_out, 8'h6C);
      ops(6'b000000, 1, 13'h0ABC);
      exp_q.push_back(VEC_TIMER0);
      put(ADDR_IRQ, 8'h6D);
      wait_q();
      check(irq_ctrl_out, 8'h4C);
      repeat (20) @(posedge sys_clk);
      #1;
      check(irq_ctrl_out, 8'h4C);
      exp_q.push_back(13'h0ABC);
      exp_q.push_back(VEC_TIMER1);
      ops(6'b001000, 1, 13'h0ABC);
      wait_q();
      check(irq_ctrl_out, 8'h0C);
      exp_q.push_back(13'h0ABC);
      ops(6'b001000, 1, 13'h0ABC);
      wait_q();
      check(irq_ctrl_out, 8'h0D);
      ops(6'b100000, 8, 13'h0200);
      fire(1'b1, 1'b0);
      repeat (20) @(posedge sys_clk);
      #1;
      check(irq_ctrl_out, 8'h2D);
      exp_q.push_back(13'h0207);
      exp_q.push_back(VEC_TIMER0);
      ops(6'b010000, 1, 13'h0300);
      wait_q();
      check(irq_ctrl_out, 8'h0C);
      check(16'(exp_q.size()), 16'h0000);
      stop_test();
   end
endmodule // mcu_stack_status_interrupt_core_bench
`default_nettype wire
